// file: rtl/fisb_pkg.sv
/*
  Constants and types for the fault interrupt status bank: register indices,
  field positions, reset values and enable-field codes.
  Assumes a 32-bit Avalon-MM slave port with a byte address.
*/
package fisb_pkg;

  // ==========================================================================
  // register map: printed indices, byte address is four times the index
  // ==========================================================================
  localparam logic [7:0] FISB_IDX_EN_PRIMARY    = 8'h50;
  localparam logic [7:0] FISB_IDX_EN_STRING     = 8'h52;
  localparam logic [7:0] FISB_IDX_FAULT_PRIMARY = 8'h54;
  localparam logic [7:0] FISB_IDX_FAULT_STRING  = 8'h56;
  localparam int         FISB_ADDR_W            = 10;

  // ==========================================================================
  // field positions (status bit; its clear bit sits one below)
  // ==========================================================================
  localparam int FISB_POS_OVP_HIGH   = 15;
  localparam int FISB_POS_HOT        = 13;
  localparam int FISB_POS_COLD       = 11;
  localparam int FISB_POS_OVP_LOW    = 7;
  localparam int FISB_POS_OVERCUR    = 5;
  localparam int FISB_POS_LOCKOUT    = 3;
  localparam int FISB_POS_TSD        = 1;
  localparam int FISB_POS_SUMMARY    = 7;
  // two-bit enable fields, given by their upper bit
  localparam int FISB_EPOS_GLOBAL    = 15;
  localparam int FISB_EPOS_OVP_HIGH  = 13;
  localparam int FISB_EPOS_TEMP      = 11;
  localparam int FISB_EPOS_OVP_LOW   = 7;
  localparam int FISB_EPOS_OVERCUR   = 5;
  localparam int FISB_EPOS_LOCKOUT   = 3;
  localparam int FISB_EPOS_TSD       = 1;
  localparam int FISB_EPOS_STRING    = 7;

  // internal flag vector layout
  localparam int FISB_F_TSD      = 0;
  localparam int FISB_F_LOCKOUT  = 1;
  localparam int FISB_F_OVERCUR  = 2;
  localparam int FISB_F_OVP_LOW  = 3;
  localparam int FISB_F_COLD     = 4;
  localparam int FISB_F_HOT      = 5;
  localparam int FISB_F_OVP_HIGH = 6;
  localparam int FISB_F_SUMMARY  = 7;
  localparam int FISB_F_SHORT    = 8;
  localparam int FISB_F_OPEN     = 9;
  localparam int FISB_F_CH0      = 10;
  localparam int FISB_NFLAGS     = 16;

  // ==========================================================================
  // enable codes and reset values
  // ==========================================================================
  localparam logic [1:0]  FISB_EN_WR_ON   = 2'h3;
  localparam logic [1:0]  FISB_EN_WR_OFF  = 2'h1;
  // enable bits: global, ovp high, temp, ovp low, overcurrent, lockout, tsd, string
  localparam logic [7:0]  FISB_EN_RESET   = 8'hCF;
  localparam logic [15:0] FISB_FLAG_RESET = 16'h0000;

  typedef struct packed {
    logic       ovp_high;
    logic       hot;
    logic       cold;
    logic       ovp_low;
    logic       overcur;
    logic       lockout;
    logic       tsd;
    logic [5:0] channel;
    logic       open;
    logic       short_str;
  } fisb_fault_type;

endpackage

// file: rtl/fisb_flag_bank.sv
/*
  Bank of sticky fault flags: a set input latches, a clear input releases.
  Assumes set and clear are synchronous single-cycle or level requests.
*/
module fisb_flag_bank
  import fisb_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [FISB_NFLAGS-1:0]  set_i,
  input  wire logic [FISB_NFLAGS-1:0]  clr_i,
  output logic      [FISB_NFLAGS-1:0]  flag_o
);

  // ==========================================================================
  // flags
  // ==========================================================================
  logic [FISB_NFLAGS-1:0] flag_ff;
  logic [FISB_NFLAGS-1:0] nxt_flag;

  genvar g;
  generate
    for (g = 0; g < FISB_NFLAGS; g++)
    begin : g_flag
      // a fault in the clearing cycle keeps the flag up
      assign nxt_flag[g] = set_i[g] | (flag_ff[g] & ~clr_i[g]);
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_ff <= FISB_FLAG_RESET;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_o = flag_ff;

endmodule // fisb_flag_bank

// file: rtl/fisb_top.sv
/*
  Fault interrupt status bank: two fault-status registers, two interrupt
  enable registers and one level interrupt output, on an Avalon-MM slave.
  Assumes fault inputs are synchronous to CLK_I and a well-behaved master.
*/
// The Avalon-MM slave port was chosen for this implementation.
module fisb_top
  import fisb_pkg::*;
(
  input  wire logic                    CLK_I,
  input  wire logic                    RST_I,
  input  wire logic [FISB_ADDR_W-1:0]  AVS_ADDRESS_I,
  input  wire logic                    AVS_READ_I,
  input  wire logic                    AVS_WRITE_I,
  input  wire logic [31:0]             AVS_WRITEDATA_I,
  input  wire logic [3:0]              AVS_BYTEENABLE_I,
  output logic      [31:0]             AVS_READDATA_O,
  output logic                         AVS_WAITREQUEST_O,
  input  wire fisb_fault_type          FAULT_I,
  output logic                         INT_O
);

  // ==========================================================================
  // decode
  // ==========================================================================
  // both bits of a pair sit in the same byte lane, so one lane check suffices
  function automatic logic pair_hit(input logic [31:0] wd, input logic [3:0] be, input int pos);
    pair_hit = wd[pos] & wd[pos-1] & be[pos/8];
  endfunction

  function automatic logic en_field(input logic old, input logic [1:0] code);
    en_field = (code == FISB_EN_WR_ON) ? 1'b1 : ((code == FISB_EN_WR_OFF) ? 1'b0 : old);
  endfunction

  logic                   waitreq_ff;
  logic                   nxt_waitreq;
  logic [31:0]            readdata_ff;
  logic [31:0]            nxt_readdata;
  logic                   int_ff;
  logic [7:0]             en_ff;
  logic [7:0]             nxt_en;
  logic [FISB_NFLAGS-1:0] flags;
  logic [FISB_NFLAGS-1:0] set_vec;
  logic [FISB_NFLAGS-1:0] clr_vec;

  wire logic request  = AVS_READ_I | AVS_WRITE_I;
  wire logic accept   = request & ~waitreq_ff;
  wire logic acc_wr   = accept & AVS_WRITE_I;
  wire logic acc_rd   = accept & AVS_READ_I;
  wire logic hit_enp  = AVS_ADDRESS_I == {FISB_IDX_EN_PRIMARY, 2'b00};
  wire logic hit_ens  = AVS_ADDRESS_I == {FISB_IDX_EN_STRING, 2'b00};
  wire logic hit_prim = AVS_ADDRESS_I == {FISB_IDX_FAULT_PRIMARY, 2'b00};
  wire logic hit_str  = AVS_ADDRESS_I == {FISB_IDX_FAULT_STRING, 2'b00};
  wire logic wr_prim  = acc_wr & hit_prim;
  wire logic wr_str   = acc_wr & hit_str;
  wire logic [31:0] wd = AVS_WRITEDATA_I;
  wire logic [3:0]  be = AVS_BYTEENABLE_I;

  // ==========================================================================
  // fault latching and paired clears
  // ==========================================================================
  wire logic any_string = |FAULT_I.channel | FAULT_I.open | FAULT_I.short_str;

  assign set_vec[FISB_F_OVP_HIGH] = FAULT_I.ovp_high;
  assign set_vec[FISB_F_HOT]      = FAULT_I.hot;
  assign set_vec[FISB_F_COLD]     = FAULT_I.cold;
  assign set_vec[FISB_F_OVP_LOW]  = FAULT_I.ovp_low;
  assign set_vec[FISB_F_OVERCUR]  = FAULT_I.overcur;
  assign set_vec[FISB_F_LOCKOUT]  = FAULT_I.lockout;
  assign set_vec[FISB_F_TSD]      = FAULT_I.tsd;
  assign set_vec[FISB_F_SUMMARY]  = any_string;
  assign set_vec[FISB_F_SHORT]    = FAULT_I.short_str;
  assign set_vec[FISB_F_OPEN]     = FAULT_I.open;
  assign set_vec[FISB_F_CH0+5:FISB_F_CH0] = FAULT_I.channel;

  wire logic clr_str = wr_str & pair_hit(wd, be, FISB_POS_SUMMARY);

  // a lone status or clear bit gives no clear at all
  assign clr_vec[FISB_F_OVP_HIGH] = wr_prim & pair_hit(wd, be, FISB_POS_OVP_HIGH);
  assign clr_vec[FISB_F_HOT]      = wr_prim & pair_hit(wd, be, FISB_POS_HOT);
  assign clr_vec[FISB_F_COLD]     = wr_prim & pair_hit(wd, be, FISB_POS_COLD);
  assign clr_vec[FISB_F_OVP_LOW]  = wr_prim & pair_hit(wd, be, FISB_POS_OVP_LOW);
  assign clr_vec[FISB_F_OVERCUR]  = wr_prim & pair_hit(wd, be, FISB_POS_OVERCUR);
  assign clr_vec[FISB_F_LOCKOUT]  = wr_prim & pair_hit(wd, be, FISB_POS_LOCKOUT);
  assign clr_vec[FISB_F_TSD]      = wr_prim & pair_hit(wd, be, FISB_POS_TSD);
  assign clr_vec[FISB_NFLAGS-1:FISB_F_SUMMARY] = {(FISB_NFLAGS-FISB_F_SUMMARY){clr_str}};

  fisb_flag_bank u_flags (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .set_i  (set_vec),
    .clr_i  (clr_vec),
    .flag_o (flags)
  );

  // ==========================================================================
  // interrupt enables
  // ==========================================================================
  // en_ff: [7] global [6] ovp high [5] temp [4] ovp low [3] overcur [2] lockout [1] tsd [0] string
  wire logic wr_enp = acc_wr & hit_enp;
  wire logic wr_ens = acc_wr & hit_ens & be[0];

  assign nxt_en[7] = (wr_enp & be[1]) ? en_field(en_ff[7], wd[FISB_EPOS_GLOBAL -: 2]) : en_ff[7];
  assign nxt_en[6] = (wr_enp & be[1]) ? en_field(en_ff[6], wd[FISB_EPOS_OVP_HIGH -: 2]) : en_ff[6];
  assign nxt_en[5] = (wr_enp & be[1]) ? en_field(en_ff[5], wd[FISB_EPOS_TEMP -: 2]) : en_ff[5];
  assign nxt_en[4] = (wr_enp & be[0]) ? en_field(en_ff[4], wd[FISB_EPOS_OVP_LOW -: 2]) : en_ff[4];
  assign nxt_en[3] = (wr_enp & be[0]) ? en_field(en_ff[3], wd[FISB_EPOS_OVERCUR -: 2]) : en_ff[3];
  assign nxt_en[2] = (wr_enp & be[0]) ? en_field(en_ff[2], wd[FISB_EPOS_LOCKOUT -: 2]) : en_ff[2];
  assign nxt_en[1] = (wr_enp & be[0]) ? en_field(en_ff[1], wd[FISB_EPOS_TSD -: 2]) : en_ff[1];
  assign nxt_en[0] = wr_ens ? en_field(en_ff[0], wd[FISB_EPOS_STRING -: 2]) : en_ff[0];

  wire logic [7:0] flag_en = {en_ff[0], en_ff[6], en_ff[5], en_ff[5], en_ff[4], en_ff[3], en_ff[2], en_ff[1]};
  wire logic       irq_req = en_ff[7] & |(flags[FISB_F_SUMMARY:0] & flag_en);

  // ==========================================================================
  // read images
  // ==========================================================================
  wire logic [15:0] prim_img = {flags[FISB_F_OVP_HIGH], 1'b0, flags[FISB_F_HOT], 1'b0,
                                flags[FISB_F_COLD], 3'b000, flags[FISB_F_OVP_LOW], 1'b0,
                                flags[FISB_F_OVERCUR], 1'b0, flags[FISB_F_LOCKOUT], 1'b0,
                                flags[FISB_F_TSD], 1'b0};
  wire logic [15:0] str_img  = {flags[FISB_NFLAGS-1:FISB_F_SUMMARY], 7'h00};
  // enable fields read 2h when on, 0h when off
  wire logic [15:0] enp_img  = {en_ff[7], 1'b0, en_ff[6], 1'b0, en_ff[5], 3'b000,
                                en_ff[4], 1'b0, en_ff[3], 1'b0, en_ff[2], 1'b0, en_ff[1], 1'b0};
  wire logic [15:0] ens_img  = {8'h00, en_ff[0], 7'h00};

  wire logic [15:0] rd_sel = hit_prim ? prim_img :
                             hit_str  ? str_img  :
                             hit_enp  ? enp_img  :
                             hit_ens  ? ens_img  : 16'h0000;

  // ==========================================================================
  // bus handshake: one wait cycle, then the access completes
  // ==========================================================================
  // reads are sampled one edge before completion; a fault in that gap shows next read
  assign nxt_waitreq  = ~(request & waitreq_ff);
  assign nxt_readdata = (request & waitreq_ff) ? {16'h0000, rd_sel} : readdata_ff;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h0000_0000;
      en_ff       <= FISB_EN_RESET;
      int_ff      <= 1'b0;
    end
    else
    begin
      waitreq_ff  <= nxt_waitreq;
      readdata_ff <= nxt_readdata;
      en_ff       <= nxt_en;
      int_ff      <= irq_req;
    end
  end

  assign AVS_WAITREQUEST_O = waitreq_ff;
  assign AVS_READDATA_O    = readdata_ff;
  assign INT_O             = int_ff;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_prim_clear(int pos);
    acc_wr && hit_prim && wd[pos] && wd[pos-1] && be[pos/8];
  endsequence

  property p_ovph_latch;
    FAULT_I.ovp_high |=> flags[FISB_F_OVP_HIGH] && prim_img[FISB_POS_OVP_HIGH];
  endproperty
  a_ovph_latch: assert property (p_ovph_latch) else $error("ovp high fault not latched");

  property p_pair_clear;
    s_prim_clear(FISB_POS_OVP_HIGH) ##0 !FAULT_I.ovp_high |=> !flags[FISB_F_OVP_HIGH];
  endproperty
  a_pair_clear: assert property (p_pair_clear) else $error("paired write did not clear");

  property p_hot_cycle;
    (FAULT_I.hot |=> flags[FISB_F_HOT]) and
    (s_prim_clear(FISB_POS_HOT) ##0 !FAULT_I.hot |=> !flags[FISB_F_HOT]);
  endproperty
  a_hot_cycle: assert property (p_hot_cycle) else $error("hot flag latch or clear wrong");

  property p_cold_latch;
    FAULT_I.cold |=> flags[FISB_F_COLD] [*2] or (flags[FISB_F_COLD] ##1 $past(clr_vec[FISB_F_COLD]));
  endproperty
  a_cold_latch: assert property (p_cold_latch) else $error("cold flag not held");

  property p_ovpl_latch;
    FAULT_I.ovp_low |=> flags[FISB_F_OVP_LOW];
  endproperty
  a_ovpl_latch: assert property (p_ovpl_latch) else $error("ovp low fault not latched");

  property p_ocp_latch;
    FAULT_I.overcur |=> flags[FISB_F_OVERCUR];
  endproperty
  a_ocp_latch: assert property (p_ocp_latch) else $error("overcurrent not latched");

  property p_lockout_latch;
    FAULT_I.lockout |=> flags[FISB_F_LOCKOUT];
  endproperty
  a_lockout_latch: assert property (p_lockout_latch) else $error("lockout not latched");

  property p_tsd_read;
    FAULT_I.tsd ##1 (request && waitreq_ff && hit_prim) |=> AVS_READDATA_O[FISB_POS_TSD];
  endproperty
  a_tsd_read: assert property (p_tsd_read) else $error("tsd not visible on read");

  property p_reserved_zero;
    acc_rd |-> AVS_READDATA_O[31:16] == 16'h0000 && !(hit_prim && |AVS_READDATA_O[9:8])
               && !(hit_str && |AVS_READDATA_O[5:0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_string_clear;
    (wr_str && pair_hit(wd, be, FISB_POS_SUMMARY) && !any_string) |=> flags[FISB_NFLAGS-1:FISB_F_SUMMARY] == 9'h000;
  endproperty
  a_string_clear: assert property (p_string_clear) else $error("string flags not cleared");

  property p_summary_set;
    FAULT_I.channel[0] |=> flags[FISB_F_CH0] && flags[FISB_F_SUMMARY];
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("channel fault not summarized");

  property p_string_enable;
    (wr_ens && wd[FISB_EPOS_STRING -: 2] == FISB_EN_WR_OFF) |=> !en_ff[0] ##0 ens_img[FISB_EPOS_STRING -: 2] == 2'h0;
  endproperty
  a_string_enable: assert property (p_string_enable) else $error("string enable write wrong");

  property p_int_follow;
    (en_ff[7] && en_ff[1] && flags[FISB_F_TSD]) |=> INT_O;
  endproperty
  a_int_follow: assert property (p_int_follow) else $error("interrupt not raised");

  property p_lone_bit;
    (wr_prim && flags[FISB_F_OVP_HIGH] && wd[FISB_POS_OVP_HIGH] != wd[FISB_POS_OVP_HIGH-1]) |=> flags[FISB_F_OVP_HIGH];
  endproperty
  a_lone_bit: assert property (p_lone_bit) else $error("lone bit cleared a flag");

  property p_cold_clear;
    s_prim_clear(FISB_POS_COLD) ##0 !FAULT_I.cold |=> !flags[FISB_F_COLD];
  endproperty
  a_cold_clear: assert property (p_cold_clear) else $error("cold flag not cleared");

  property p_ovpl_clear;
    s_prim_clear(FISB_POS_OVP_LOW) ##0 !FAULT_I.ovp_low |=> !flags[FISB_F_OVP_LOW];
  endproperty
  a_ovpl_clear: assert property (p_ovpl_clear) else $error("ovp low flag not cleared");

  property p_ocp_clear;
    s_prim_clear(FISB_POS_OVERCUR) ##0 !FAULT_I.overcur |=> !flags[FISB_F_OVERCUR];
  endproperty
  a_ocp_clear: assert property (p_ocp_clear) else $error("overcurrent flag not cleared");

  property p_lockout_clear;
    s_prim_clear(FISB_POS_LOCKOUT) ##0 !FAULT_I.lockout |=> !flags[FISB_F_LOCKOUT];
  endproperty
  a_lockout_clear: assert property (p_lockout_clear) else $error("lockout flag not cleared");

  // a fault present during its own clearing write must survive it
  property p_tsd_hold;
    s_prim_clear(FISB_POS_TSD) ##0 FAULT_I.tsd |=> flags[FISB_F_TSD];
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("tsd flag lost during clear");

  property p_string_lone;
    (wr_str && flags[FISB_F_SUMMARY] && wd[FISB_POS_SUMMARY] != wd[FISB_POS_SUMMARY-1]) |=> flags[FISB_F_SUMMARY];
  endproperty
  a_string_lone: assert property (p_string_lone) else $error("lone bit cleared summary");

  property p_string_on;
    (wr_ens && wd[FISB_EPOS_STRING -: 2] == FISB_EN_WR_ON) |=> en_ff[0];
  endproperty
  a_string_on: assert property (p_string_on) else $error("string enable not set");

  property p_string_keep;
    (wr_ens && wd[FISB_EPOS_STRING -: 2] == 2'h2) |=> en_ff[0] == $past(en_ff[0]);
  endproperty
  a_string_keep: assert property (p_string_keep) else $error("string enable changed by no-op code");

  property p_int_global_off;
    !en_ff[7] |=> !INT_O;
  endproperty
  a_int_global_off: assert property (p_int_global_off) else $error("interrupt high while disabled");

  property p_summary_int;
    (en_ff[7] && en_ff[0] && flags[FISB_F_SUMMARY]) |=> INT_O;
  endproperty
  a_summary_int: assert property (p_summary_int) else $error("summary did not raise interrupt");

endmodule // fisb_top

// file: tb/fisb_host_model.sv
/*
  Host processor model: an Avalon-MM master that reads and writes the fault
  status bank on request of the testbench.
  Assumes one clock domain and a slave that answers through waitrequest.
*/
module fisb_host_model
  import fisb_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   waitrequest_i,
  input  wire logic [31:0]            readdata_i,
  output logic      [FISB_ADDR_W-1:0] address_o,
  output logic                        read_o,
  output logic                        write_o,
  output logic      [31:0]            writedata_o,
  output logic      [3:0]             byteenable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    address_o    = '0;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0000_0000;
    byteenable_o = 4'h0;
  end

  // ==========================================================================
  // one bus access, held until the edge that sees waitrequest low
  // ==========================================================================
  task automatic access(input logic is_wr, input logic [FISB_ADDR_W-1:0] addr,
                        input logic [15:0] data, input logic [3:0] be, output logic [31:0] rdata);
    @(posedge clk_i);
    address_o    <= addr;
    writedata_o  <= {16'h0000, data};
    byteenable_o <= be;
    read_o       <= !is_wr;
    write_o      <= is_wr;
    do
      @(posedge clk_i);
    while (waitrequest_i !== 1'b0);
    rdata = readdata_i;
    read_o       <= 1'b0;
    write_o      <= 1'b0;
    // released data lines must not look like a still-valid word
    writedata_o  <= ~writedata_o;
  endtask
endmodule // fisb_host_model

// file: tb/testbench.sv
/*
  Self-checking testbench of the fault interrupt status bank.
  Assumes the host model for bus traffic and drives the fault inputs itself.
*/
module testbench
  import fisb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [FISB_ADDR_W-1:0] A_EN1   = {FISB_IDX_EN_PRIMARY, 2'b00};
  localparam logic [FISB_ADDR_W-1:0] A_EN2   = {FISB_IDX_EN_STRING, 2'b00};
  localparam logic [FISB_ADDR_W-1:0] A_STAT1 = {FISB_IDX_FAULT_PRIMARY, 2'b00};
  localparam logic [FISB_ADDR_W-1:0] A_STAT2 = {FISB_IDX_FAULT_STRING, 2'b00};
  localparam logic [FISB_ADDR_W-1:0] A_BAD   = 10'h200;
  // status bit of each primary fault, in fault-input order
  localparam logic [15:0] POS [7] = '{16'h8000, 16'h2000, 16'h0800, 16'h0080,
                                      16'h0020, 16'h0008, 16'h0002};
  localparam logic [0:6]  INT_EXP = 7'h47;

  logic                   clk;
  logic                   rst;
  logic [FISB_ADDR_W-1:0] address;
  logic                   read;
  logic                   write;
  logic [31:0]            writedata;
  logic [31:0]            readdata;
  logic [3:0]             byteenable;
  logic                   waitrequest;
  fisb_fault_type         fault;
  fisb_fault_type         fault_v;
  logic                   irq;
  int                     err_count;
  int                     comparisons;
  int                     cycles;
  int                     i;

  fisb_top fisb_top_inst (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(address), .AVS_READ_I(read),
    .AVS_WRITE_I(write), .AVS_WRITEDATA_I(writedata), .AVS_BYTEENABLE_I(byteenable),
    .AVS_READDATA_O(readdata), .AVS_WAITREQUEST_O(waitrequest), .FAULT_I(fault), .INT_O(irq));

  fisb_host_model fisb_host_model_inst (.clk_i(clk), .waitrequest_i(waitrequest), .readdata_i(readdata),
    .address_o(address), .read_o(read), .write_o(write), .writedata_o(writedata),
    .byteenable_o(byteenable));

  initial
  begin
    clk = 1'b0;
    cycles = 0;
  end

  always #10 clk = ~clk;

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_be(input logic [FISB_ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] lanes);
    logic [31:0] unused;
    fisb_host_model_inst.access(1'b1, a, d, lanes, unused);
  endtask

  task automatic wr(input logic [FISB_ADDR_W-1:0] a, input logic [15:0] d);
    wr_be(a, d, 4'h3);
  endtask

  task automatic rd_chk(input logic [FISB_ADDR_W-1:0] a, input logic [15:0] exp);
    logic [31:0] d;
    fisb_host_model_inst.access(1'b0, a, 16'h0000, 4'h3, d);
    chk(d, {16'h0000, exp});
  endtask

  // the interrupt output lags its cause by up to two edges
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic pulse(input fisb_fault_type f);
    @(posedge clk);
    fault <= f;
    @(posedge clk);
    fault <= '0;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    rst = 1'b1;
    fault = '0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(A_STAT1, 16'h0000);
    rd_chk(A_STAT2, 16'h0000);
    rd_chk(A_EN1, 16'hA02A);
    rd_chk(A_EN2, 16'h0080);
    wr(A_BAD, 16'hFFFF);
    rd_chk(A_BAD, 16'h0000);
    wr(A_STAT1, 16'h0300);
    rd_chk(A_STAT1, 16'h0000);
    irq_chk(1'b0);
    for (i = 0; i < 7; i++)
    begin
      pulse(fisb_fault_type'(15'h4000 >> i));
      irq_chk(INT_EXP[i]);
      rd_chk(A_STAT1, POS[i]);
      wr(A_STAT1, POS[i]);
      wr(A_STAT1, POS[i] >> 1);
      rd_chk(A_STAT1, POS[i]);
      // the pair written with its own byte lane disabled must not clear
      wr_be(A_STAT1, POS[i] | (POS[i] >> 1), (POS[i] > 16'h00FF) ? 4'h1 : 4'h2);
      rd_chk(A_STAT1, POS[i]);
      wr(A_STAT1, POS[i] | (POS[i] >> 1));
      rd_chk(A_STAT1, 16'h0000);
      irq_chk(1'b0);
    end
    fault_v = '0;
    fault_v.channel = 6'h21;
    fault_v.short_str = 1'b1;
    pulse(fault_v);
    irq_chk(1'b1);
    rd_chk(A_STAT2, 16'h8580);
    fault_v.channel = 6'h3F;
    fault_v.open = 1'b1;
    pulse(fault_v);
    rd_chk(A_STAT2, 16'hFF80);
    wr(A_STAT2, 16'h0040);
    rd_chk(A_STAT2, 16'hFF80);
    wr(A_STAT2, 16'h00C0);
    rd_chk(A_STAT2, 16'h0000);
    irq_chk(1'b0);
    wr(A_EN2, 16'h0040);
    rd_chk(A_EN2, 16'h0000);
    fault_v = '0;
    fault_v.open = 1'b1;
    pulse(fault_v);
    irq_chk(1'b0);
    wr(A_EN2, 16'h0080);
    rd_chk(A_EN2, 16'h0000);
    wr(A_EN2, 16'h00C0);
    rd_chk(A_EN2, 16'h0080);
    irq_chk(1'b1);
    wr(A_EN1, 16'h4000);
    rd_chk(A_EN1, 16'h202A);
    irq_chk(1'b0);
    wr(A_EN1, 16'hC000);
    rd_chk(A_EN1, 16'hA02A);
    irq_chk(1'b1);
    wr(A_STAT2, 16'h00C0);
    irq_chk(1'b0);
    // a fault still present during the clearing write keeps its flag
    @(posedge clk);
    fault.tsd <= 1'b1;
    wr(A_STAT1, 16'h0003);
    rd_chk(A_STAT1, 16'h0002);
    @(posedge clk);
    fault <= '0;
    wr(A_STAT1, 16'h0003);
    rd_chk(A_STAT1, 16'h0000);
    stop_test();
  end
endmodule // testbench
